// File: rtl/rerr_coll_capture.v
// First bit-collision position capture for one received frame
`timescale 1ns/10ps
module rerr_coll_capture
#(
  parameter IDX_W = 8
)
(
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_i,
  // Receiver events
  input  wire             prepare_i,
  input  wire             collision_i,
  input  wire             type_b_i,
  input  wire [IDX_W-1:0] bit_index_i,
  // Captured position
  output wire [IDX_W-1:0] collision_index_o,
  output wire             captured_o
);

  reg [IDX_W-1:0] index_q;
  reg [IDX_W-1:0] index_d;
  reg             seen_q;
  reg             seen_d;

  // Only the first collision of a frame is kept; type B never reports one
  always @*
  begin
    index_d = index_q;
    seen_d  = seen_q;
    if (prepare_i)
    begin
      index_d = {IDX_W{1'b0}};
      seen_d  = 1'b0;
    end
    else if (collision_i && !type_b_i && !seen_q)
    begin
      index_d = bit_index_i;
      seen_d  = 1'b1;
    end
  end

  // Position and capture state
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      index_q <= {IDX_W{1'b0}};
      seen_q  <= 1'b0;
    end
    else
    begin
      index_q <= index_d;
      seen_q  <= seen_d;
    end
  end

  assign collision_index_o = index_q;
  assign captured_o        = seen_q;

endmodule

// File: rtl/rerr_regs.vh
// Register offsets, field positions and reset values of the error status group
`ifndef RERR_REGS_VH
`define RERR_REGS_VH

// Register port geometry
`define RERR_ADDR_W          6
`define RERR_DATA_W          8

// Register offsets
`define RERR_CTRL_ADDR       6'h09
`define RERR_ERR_FLAGS_ADDR  6'h0A
`define RERR_COLL_POS_ADDR   6'h0B
`define RERR_TIMER_VAL_ADDR  6'h0C
`define RERR_CRC_LOW_ADDR    6'h0D
`define RERR_CRC_HIGH_ADDR   6'h0E

// Error flag bit positions
`define RERR_BIT_RSVD        7
`define RERR_BIT_KEY         6
`define RERR_BIT_NVM         5
`define RERR_BIT_OVFL        4
`define RERR_BIT_CRC         3
`define RERR_BIT_SOF         2
`define RERR_BIT_PARITY      1
`define RERR_BIT_COLL        0

// Flush control bit in the control register
`define RERR_BIT_FLUSH       0

// Reset values
`define RERR_ERR_FLAGS_RST   8'h40
`define RERR_COLL_POS_RST    8'h00
`define RERR_VOLATILE_RST    8'h00
`define RERR_RDATA_UNMAPPED  8'h00

`endif

// File: rtl/rerr_status_regs.v
// Error flag, collision position, timer value and checksum result registers
//
// Functional notes
// - Error flags hold last command outcome, read-only
// - Key error bit 6, cleared at key-load start
// - Rights error bit 5, cleared at NVM command
// - Overflow bit 4 on write into full FIFO
// - Checksum error bit 3 when check enabled, fails
// - Receiver prepare clears bits 3 down to 0
// - Start-of-frame error sets bit 2
// - Parity failure sets bit 1
// - Collision sets bit 0, type A only
// - Collision register holds first collided bit index
// - Type B never reports collision position
// - Timer register shows live timer count
// - Low checksum byte valid while done is 1
// - High byte ignored for 8-bit checksum
// - Flush write clears pointers, length and overflow
`timescale 1ns/10ps
`include "rerr_regs.vh"
module rerr_status_regs
#(
  parameter ADDR_W   = `RERR_ADDR_W,
  parameter DATA_W   = `RERR_DATA_W,
  parameter TIMER_W  = 8,
  parameter CRC_W    = 16
)
(
  // Clock and reset
  input  wire                sys_clk_i,
  input  wire                rst_i,

  // Host register port
  input  wire [ADDR_W-1:0]   reg_addr_i,
  input  wire                reg_rd_i,
  input  wire                reg_wr_i,
  input  wire [DATA_W-1:0]   reg_wdata_i,
  output wire [DATA_W-1:0]   reg_rdata_o,
  output wire                reg_rvalid_o,
  output wire                reg_hit_o,

  // Key loading command events
  input  wire                key_cmd_start_i,
  input  wire                key_format_bad_i,

  // Non-volatile memory command events
  input  wire                nvm_cmd_start_i,
  input  wire                nvm_rights_violation_i,

  // FIFO write attempts
  input  wire                fifo_full_i,
  input  wire                host_fifo_wr_i,
  input  wire                int_fifo_wr_i,

  // Receiver events
  input  wire                receiver_prepare_state_i,
  input  wire                receive_checksum_enable_i,
  input  wire                rx_checksum_fail_i,
  input  wire                rx_sof_bad_i,
  input  wire                rx_parity_fail_i,
  input  wire                rx_collision_i,
  input  wire [7:0]          rx_bit_index_i,
  input  wire                proto_type_b_i,

  // Timer and checksum engines
  input  wire [TIMER_W-1:0]  timer_count_i,
  input  wire [CRC_W-1:0]    checksum_value_i,
  input  wire                checksum_done_i,
  input  wire                checksum_8bit_i,

  // Status outputs
  output wire [7:0]          error_flags_o,
  output wire [7:0]          collision_index_o,
  output wire [TIMER_W-1:0]  timer_count_value_o,
  output wire [7:0]          checksum_result_low_o,
  output wire [7:0]          checksum_result_high_o,
  output wire                checksum_done_o,
  output wire                checksum_high_valid_o,

  // FIFO flush strobe to the FIFO engine
  output wire                buffer_flush_control_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]         err_flags_q;
  wire [7:0]         err_flags_d;
  reg  [TIMER_W-1:0] timer_q;
  reg  [7:0]         crc_low_q;
  reg  [7:0]         crc_high_q;
  reg                crc_done_q;
  reg                crc_high_ok_q;
  reg                flush_q;
  reg  [DATA_W-1:0]  rdata_q;
  reg  [DATA_W-1:0]  rdata_d;
  reg                rvalid_q;
  reg                hit_q;
  reg                hit_d;

  // Event vectors for the flag bank
  reg  [7:0]         set_vec;
  reg  [7:0]         clr_vec;

  // Decoded host strobes, FIFO write attempt and collision capture
  wire               ctrl_wr;
  wire               flush_req;
  wire               fifo_wr_attempt;
  wire [7:0]         coll_index;
  wire               coll_captured;

  // ----------------------------------------------------------------
  // Host flush request
  // ----------------------------------------------------------------

  // A write to the control register, which lives outside this group
  assign ctrl_wr = reg_wr_i && (reg_addr_i == `RERR_CTRL_ADDR);

  // A control write with the flush bit set flushes the FIFO
  assign flush_req = ctrl_wr && reg_wdata_i[`RERR_BIT_FLUSH];

  // Any write into the FIFO, from host or internal engine
  assign fifo_wr_attempt = host_fifo_wr_i | int_fifo_wr_i;

  // ----------------------------------------------------------------
  // Flag set and clear sources
  // ----------------------------------------------------------------

  // Set sources per flag bit
  always @*
  begin
    set_vec = 8'h00;
    set_vec[`RERR_BIT_KEY] = key_format_bad_i;
    set_vec[`RERR_BIT_NVM] = nvm_rights_violation_i;
    set_vec[`RERR_BIT_OVFL] = fifo_full_i & fifo_wr_attempt;
    set_vec[`RERR_BIT_CRC] = receive_checksum_enable_i
                              & rx_checksum_fail_i;
    set_vec[`RERR_BIT_SOF] = rx_sof_bad_i;
    set_vec[`RERR_BIT_PARITY] = rx_parity_fail_i;
    set_vec[`RERR_BIT_COLL] = rx_collision_i & ~proto_type_b_i;
  end

  // Clear sources per flag bit; the reserved bit is held clear
  always @*
  begin
    clr_vec = 8'h00;
    clr_vec[`RERR_BIT_RSVD] = 1'b1;
    clr_vec[`RERR_BIT_KEY] = key_cmd_start_i;
    clr_vec[`RERR_BIT_NVM] = nvm_cmd_start_i;
    clr_vec[`RERR_BIT_OVFL] = flush_req;
    clr_vec[`RERR_BIT_CRC] = receiver_prepare_state_i;
    clr_vec[`RERR_BIT_SOF] = receiver_prepare_state_i;
    clr_vec[`RERR_BIT_PARITY] = receiver_prepare_state_i;
    clr_vec[`RERR_BIT_COLL] = receiver_prepare_state_i;
  end

  // ----------------------------------------------------------------
  // Flag bank: sticky bits, a set in the clearing cycle wins
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_flag
      assign err_flags_d[gi] = set_vec[gi]
                               | (err_flags_q[gi] & ~clr_vec[gi]);
    end
  endgenerate

  // Flag register; only hardware events and the flush write (clears bit 4) move it, other host writes never do
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      err_flags_q <= `RERR_ERR_FLAGS_RST;
    else
      err_flags_q <= err_flags_d;
  end

  // ----------------------------------------------------------------
  // Collision position
  // ----------------------------------------------------------------

  // Keeps the first collided bit of the frame under way
  rerr_coll_capture
  #(
    .IDX_W (8)
  )
  u_coll
  (
    .sys_clk_i         (sys_clk_i),
    .rst_i             (rst_i),
    .prepare_i         (receiver_prepare_state_i),
    .collision_i       (rx_collision_i),
    .type_b_i          (proto_type_b_i),
    .bit_index_i       (rx_bit_index_i),
    .collision_index_o (coll_index),
    .captured_o        (coll_captured)
  );

  // ----------------------------------------------------------------
  // Timer and checksum mirrors
  // ----------------------------------------------------------------

  // Live timer copy, one cycle behind the timer engine
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      timer_q <= {TIMER_W{1'b0}};
    end
    else
    begin
      timer_q <= timer_count_i;
    end
  end

  // Checksum result bytes, one cycle behind the checksum engine
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      crc_low_q  <= `RERR_VOLATILE_RST;
      crc_high_q <= `RERR_VOLATILE_RST;
    end
    else
    begin
      crc_low_q  <= checksum_value_i[7:0];
      crc_high_q <= checksum_value_i[15:8];
    end
  end

  // Result qualifiers; the high byte is unusable after an 8-bit run
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      crc_done_q    <= 1'b0;
      crc_high_ok_q <= 1'b0;
    end
    else
    begin
      crc_done_q    <= checksum_done_i;
      crc_high_ok_q <= checksum_done_i & ~checksum_8bit_i;
    end
  end

  // ----------------------------------------------------------------
  // Flush strobe
  // ----------------------------------------------------------------

  // One-cycle pulse that resets FIFO pointers and length in the engine
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      flush_q <= 1'b0;
    else
      flush_q <= flush_req;
  end

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------

  // Read mux; returns live state and changes nothing
  always @*
  begin
    rdata_d = `RERR_RDATA_UNMAPPED;
    hit_d   = 1'b0;
    case (reg_addr_i)
      `RERR_ERR_FLAGS_ADDR:
      begin
        rdata_d = err_flags_q;
        hit_d   = 1'b1;
      end
      `RERR_COLL_POS_ADDR:
      begin
        rdata_d = coll_index;
        hit_d   = 1'b1;
      end
      `RERR_TIMER_VAL_ADDR:
      begin
        rdata_d = timer_q[7:0];
        hit_d   = 1'b1;
      end
      `RERR_CRC_LOW_ADDR:
      begin
        rdata_d = crc_low_q;
        hit_d   = 1'b1;
      end
      `RERR_CRC_HIGH_ADDR:
      begin
        rdata_d = crc_high_q;
        hit_d   = 1'b1;
      end
      default:
      begin
        rdata_d = `RERR_RDATA_UNMAPPED;
        hit_d   = 1'b0;
      end
    endcase
  end

  // Answer strobe, one cycle after each read strobe
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= reg_rd_i;
  end

  // Read data is captured on the strobe and held until the next read
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_q  <= `RERR_RDATA_UNMAPPED;
      hit_q    <= 1'b0;
    end
    else
    begin
      if (reg_rd_i)
      begin
        rdata_q <= rdata_d;
        hit_q   <= hit_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign reg_rdata_o            = rdata_q;
  assign reg_rvalid_o           = rvalid_q;
  assign reg_hit_o              = hit_q;
  assign error_flags_o          = err_flags_q;
  assign collision_index_o      = coll_index;
  assign timer_count_value_o    = timer_q;
  assign checksum_result_low_o  = crc_low_q;
  assign checksum_result_high_o = crc_high_q;
  assign checksum_done_o        = crc_done_q;
  assign checksum_high_valid_o  = crc_high_ok_q;
  assign buffer_flush_control_o = flush_q;

endmodule

// File: verif/rerr_host_model.sv
// Host model driving the register port of the error status group
`timescale 1ns/10ps
module rerr_host_model
(
  input  wire       sys_clk_i,
  input  wire [7:0] reg_rdata_i,
  input  wire       reg_rvalid_i,
  input  wire       reg_hit_i,
  output reg  [5:0] reg_addr_o,
  output reg        reg_rd_o,
  output reg        reg_wr_o,
  output reg  [7:0] reg_wdata_o
);
  // Idle bus at time zero
  initial
  begin
    reg_addr_o = 6'h3F;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'hA5;
  end
  // Read strobe for one edge, answer taken one cycle later
  task rd_reg(input [5:0] a, output [7:0] d, output h, output ok);
    @(posedge sys_clk_i) #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge sys_clk_i) #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;  // Released address shows a changed pattern
    ok = (reg_rvalid_i === 1'b1);
    d = reg_rdata_i;
    h = reg_hit_i;
  endtask
  // Write strobe for one edge
  task wr_reg(input [5:0] a, input [7:0] d);
    @(posedge sys_clk_i) #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge sys_clk_i) #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// File: verif/rerr_status_regs_properties.sv
// Concurrent checks on the error status register group
`timescale 1ns/10ps
module rerr_status_regs_properties
(
  input wire       sys_clk_i,
  input wire       rst_i,
  input wire [5:0] reg_addr_i,
  input wire       reg_rd_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       reg_rvalid_o,
  input wire       reg_hit_o,
  input wire       key_format_bad_i,
  input wire       fifo_full_i,
  input wire       host_fifo_wr_i,
  input wire       int_fifo_wr_i,
  input wire       receiver_prepare_state_i,
  input wire       receive_checksum_enable_i,
  input wire       rx_checksum_fail_i,
  input wire       rx_sof_bad_i,
  input wire       rx_parity_fail_i,
  input wire       rx_collision_i,
  input wire [7:0] rx_bit_index_i,
  input wire       proto_type_b_i,
  input wire [7:0] error_flags_o,
  input wire [7:0] collision_index_o,
  input wire       buffer_flush_control_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Overflow attempt, flush write and its one-cycle strobe
  wire ovfl_try = fifo_full_i && (host_fifo_wr_i || int_fifo_wr_i);
  sequence s_flush_wr;
    reg_wr_i && reg_addr_i == 6'h09 && reg_wdata_i[0] && !ovfl_try;
  endsequence
  sequence s_flush_pulse;
    (buffer_flush_control_o && !error_flags_o[4]) ##1 !buffer_flush_control_o;
  endsequence
  a_read_flags: assert property (reg_rd_i && reg_addr_i == 6'h0A |=> reg_rvalid_o && reg_hit_o
    && reg_rdata_o == $past(error_flags_o)) else $error("flag read wrong");
  a_key_set: assert property (key_format_bad_i |=> error_flags_o[6])
    else $error("key flag not set");
  a_ovfl_set: assert property (ovfl_try |=> error_flags_o[4])
    else $error("overflow flag not set");
  a_crc_gate: assert property (rx_checksum_fail_i && !error_flags_o[3]
    |=> error_flags_o[3] == $past(receive_checksum_enable_i)) else $error("crc flag wrong");
  a_prep_clear: assert property (receiver_prepare_state_i && !(rx_checksum_fail_i || rx_sof_bad_i
    || rx_parity_fail_i || rx_collision_i) |=> error_flags_o[3:0] == 4'h0
    && collision_index_o == 8'h00) else $error("prepare did not clear");
  a_coll_first: assert property (rx_collision_i && !proto_type_b_i && !error_flags_o[0]
    && !receiver_prepare_state_i |=> error_flags_o[0]
    && collision_index_o == $past(rx_bit_index_i)) else $error("collision capture wrong");
  a_typeb_quiet: assert property (proto_type_b_i && !receiver_prepare_state_i
    |=> $stable(collision_index_o) && $stable(error_flags_o[0]))
    else $error("type B collision shown");
  a_flush_pulse: assert property (s_flush_wr |=> s_flush_pulse)
    else $error("flush strobe wrong");
endmodule
bind rerr_status_regs rerr_status_regs_properties u_props (.*);

// File: verif/tb.sv
// Self-checking bench for the error status register group
`timescale 1ns/10ps
module tb;
  // Clock, reset, register port and status outputs
  reg        sys_clk_i = 1'b0;
  reg        rst_i = 1'b1;
  wire [5:0] reg_addr_i;
  wire [7:0] reg_wdata_i, reg_rdata_o, error_flags_o, collision_index_o, timer_count_value_o;
  wire [7:0] checksum_result_low_o, checksum_result_high_o;
  wire       reg_rd_i, reg_wr_i, reg_rvalid_o, reg_hit_o, checksum_done_o;
  wire       checksum_high_valid_o, buffer_flush_control_o;
  // Event pulses packed in one vector, and levels
  reg  [9:0] ev = 10'h000;
  wire       key_cmd_start_i, key_format_bad_i, nvm_cmd_start_i, nvm_rights_violation_i;
  wire       host_fifo_wr_i, int_fifo_wr_i, rx_checksum_fail_i, rx_sof_bad_i;
  wire       rx_parity_fail_i, rx_collision_i;
  assign {rx_collision_i, rx_parity_fail_i, rx_sof_bad_i, rx_checksum_fail_i, int_fifo_wr_i,
    host_fifo_wr_i, nvm_rights_violation_i, nvm_cmd_start_i, key_format_bad_i,
    key_cmd_start_i} = ev;
  reg        fifo_full_i = 1'b0, receiver_prepare_state_i = 1'b0, proto_type_b_i = 1'b0;
  reg        receive_checksum_enable_i = 1'b0, checksum_done_i = 1'b0, checksum_8bit_i = 1'b0;
  reg  [7:0] rx_bit_index_i = 8'h00, timer_count_i = 8'h00;
  reg [15:0] checksum_value_i = 16'h0000;
  integer    bad_count = 0, comparisons = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  rerr_status_regs u_dut (.*);
  rerr_host_model u_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_hit_i(reg_hit_o), .reg_addr_o(reg_addr_i),
    .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
  // Compare and count
  task check(input [7:0] got, input [7:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read one register, compare data, answer and hit
  task rchk(input [5:0] a, input [7:0] exp, input hexp);
    reg [7:0] d;
    reg       h, ok;
    u_host.rd_reg(a, d, h, ok);
    check({6'h00, ok, h}, {6'h00, 1'b1, hexp});
    check(d, exp);
  endtask
  // Raise the chosen event pulses for one edge
  task pulse(input [9:0] m);
    @(posedge sys_clk_i) #1;
    ev = m;
    @(posedge sys_clk_i) #1;
    ev = 10'h000;
  endtask
  task t_reset;
    rchk(6'h0A, 8'h40, 1'b1);
    rchk(6'h0B, 8'h00, 1'b1);
    rchk(6'h20, 8'h00, 1'b0);
    u_host.wr_reg(6'h0A, 8'h00);
    u_host.wr_reg(6'h0B, 8'hFF);
    rchk(6'h0A, 8'h40, 1'b1);
    rchk(6'h0B, 8'h00, 1'b1);
    $display("reset test done");
  endtask
  task t_cmd;
    pulse(10'h001);
    rchk(6'h0A, 8'h00, 1'b1);
    pulse(10'h002);
    rchk(6'h0A, 8'h40, 1'b1);
    pulse(10'h008);
    rchk(6'h0A, 8'h60, 1'b1);
    rchk(6'h0A, 8'h60, 1'b1);
    pulse(10'h005);
    rchk(6'h0A, 8'h00, 1'b1);
    $display("command test done");
  endtask
  task t_fifo;
    pulse(10'h010);
    rchk(6'h0A, 8'h00, 1'b1);
    fifo_full_i = 1'b1;
    pulse(10'h020);
    rchk(6'h0A, 8'h10, 1'b1);
    u_host.wr_reg(6'h09, 8'hFE);
    rchk(6'h0A, 8'h10, 1'b1);
    u_host.wr_reg(6'h09, 8'h01);
    check({7'h00, buffer_flush_control_o}, 8'h01);
    rchk(6'h0A, 8'h00, 1'b1);
    fifo_full_i = 1'b0;
    $display("fifo test done");
  endtask
  task t_rx;
    pulse(10'h040);
    rchk(6'h0A, 8'h00, 1'b1);
    receive_checksum_enable_i = 1'b1;
    rx_bit_index_i = 8'h05;
    pulse(10'h240);
    rchk(6'h0A, 8'h09, 1'b1);
    rx_bit_index_i = 8'h08;
    pulse(10'h380);
    rchk(6'h0A, 8'h0F, 1'b1);
    rchk(6'h0B, 8'h05, 1'b1);
    check(collision_index_o, 8'h05);
    receiver_prepare_state_i = 1'b1;
    pulse(10'h000);
    receiver_prepare_state_i = 1'b0;
    rchk(6'h0A, 8'h00, 1'b1);
    pulse(10'h200);
    rchk(6'h0B, 8'h08, 1'b1);
    proto_type_b_i = 1'b1;
    receiver_prepare_state_i = 1'b1;
    pulse(10'h000);
    receiver_prepare_state_i = 1'b0;
    pulse(10'h200);
    rchk(6'h0A, 8'h00, 1'b1);
    rchk(6'h0B, 8'h00, 1'b1);
    proto_type_b_i = 1'b0;
    $display("receive test done");
  endtask
  task t_mirror;
    timer_count_i = 8'h5A;
    checksum_value_i = 16'hC3A7;
    checksum_done_i = 1'b1;
    rchk(6'h0C, 8'h5A, 1'b1);
    check(timer_count_value_o, 8'h5A);
    check(checksum_result_low_o, 8'hA7);
    check(checksum_result_high_o, 8'hC3);
    check({7'h00, checksum_done_o}, 8'h01);
    rchk(6'h0D, 8'hA7, 1'b1);
    rchk(6'h0E, 8'hC3, 1'b1);
    check({7'h00, checksum_high_valid_o}, 8'h01);
    checksum_8bit_i = 1'b1;
    pulse(10'h000);
    check({7'h00, checksum_high_valid_o}, 8'h00);
    $display("mirror test done");
  endtask
  // Counts and verdict
  task close_out;
    $display("counts: %0d mismatches, %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    t_reset;
    t_cmd;
    t_fifo;
    t_rx;
    t_mirror;
    close_out;
  end
  // Run limit against a hang
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count = bad_count + 1;
    $display("FAIL at %0t: run limit reached", $time);
    close_out;
  end
endmodule
